// *** verilog/afs_regs.v ***
// Purpose: fault configuration/status and clip threshold registers
// Assumes: control port decoded upstream into a synchronous byte bus
// Notes:   fault sources are levels from the analog monitors
`timescale 1ns/1ns
`include "afs_defines.vh"

// Contract
// - the two-bit overcurrent select picks 100, 75, 50 or 25 percent trip.
// - the clock fault flag in bit 3 follows the clock error, no latch.
// - overcurrent sets bit 2 and halts until shutdown is toggled.
// - dc offset error sets bit 1 and halts until shutdown is toggled.
// - over-temperature sets bit 0 and halts until shutdown is toggled.
// - bits 7:6 read zero and the four flags ignore writes.
// - the 20-bit clip threshold is upper, middle and lower fields joined.
// - address 0x10 holds threshold bits 13:6, read and write.
// - address 0x11 bits 7:2 hold threshold bits 5:0, read and write.
// - low shutdown pin or cleared shutdown bit enters shutdown.
// - flags in bits 3:0 are read-only, select in bits 5:4 is read/write.
module afs_regs (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        reg_ack,
    // shutdown sources
    input  wire        amp_shutdown_n,
    input  wire        shutdown_bit_n,
    // fault monitors
    input  wire        clk_error,
    input  wire        overcurrent_event,
    input  wire        dc_offset_event,
    input  wire        overtemp_event,
    input  wire [7:0]  oc_nominal,
    // clipper
    input  wire [5:0]  clip_threshold_upper,
    output wire [19:0] clip_threshold,
    output wire [7:0]  clip_threshold_middle_out,
    output wire [5:0]  clip_threshold_lower_out,
    // status to power stage
    output reg  [7:0]  oc_trip_level,
    output reg         amp_run
);
    // latched faults share one vector, indexed by their status bit
    localparam NUM_LATCHED = 3;

    reg  [1:0] overcurrent_threshold_select;
    reg        clock_fault_flag;
    wire       overcurrent_fault_flag;
    wire       dc_offset_fault_flag;
    wire       overtemp_fault_flag;
    reg  [7:0] clip_mid;
    reg  [5:0] clip_low;
    reg  [1:0] clip_low_rsvd;
    reg        shutdown_q;
    wire [7:0] next_oc_trip;
    wire [2:0] fault_event;
    reg  [2:0] fault_latched;
    wire [2:0] next_fault_latched;
    wire       any_latched;
    wire       next_amp_run;

    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    function latch_next;
        input event_now;
        input flag_now;
        input clear_now;
        begin
            // set wins: an event in the release cycle must not be lost
            latch_next = event_now | (flag_now & ~clear_now);
        end
    endfunction

    function [7:0] fault_byte;
        input [1:0] sel;
        input       clk_f;
        input [2:0] latched;
        begin
            // reserved bits are constant zero, never stored
            fault_byte = {`AFS_RSVD_RESET, sel, clk_f, latched};
        end
    endfunction

    // shutdown from either path; a clean pass through it clears faults
    wire in_shutdown = ~amp_shutdown_n | ~shutdown_bit_n;
    // release edge counts as the toggle, so a fault held high re-latches
    wire toggled     = shutdown_q & ~in_shutdown;
    wire wr_fault    = reg_wr & hit(reg_addr, `AFS_ADDR_FAULT);
    wire wr_mid      = reg_wr & hit(reg_addr, `AFS_ADDR_CLIP_MID);
    wire wr_low      = reg_wr & hit(reg_addr, `AFS_ADDR_CLIP_LOW);

    assign reg_ack = reg_wr | reg_rd;

    afs_oc_scale u_scale (
        .overcurrent_threshold_select (overcurrent_threshold_select),
        .oc_nominal                   (oc_nominal),
        .oc_trip                      (next_oc_trip)
    );

    assign fault_event[`AFS_BIT_OCE] = overcurrent_event;
    assign fault_event[`AFS_BIT_DCE] = dc_offset_event;
    assign fault_event[`AFS_BIT_OTE] = overtemp_event;

    genvar g;
    generate
        for (g = 0; g < NUM_LATCHED; g = g + 1) begin : g_latch
            assign next_fault_latched[g] = latch_next(fault_event[g],
                fault_latched[g], toggled);
        end
    endgenerate

    assign overcurrent_fault_flag = fault_latched[`AFS_BIT_OCE];
    assign dc_offset_fault_flag   = fault_latched[`AFS_BIT_DCE];
    assign overtemp_fault_flag    = fault_latched[`AFS_BIT_OTE];
    assign any_latched = |(fault_latched & ~{NUM_LATCHED{toggled}});
    // a fresh event halts at once, not one cycle after it latches
    assign next_amp_run = ~in_shutdown & ~clk_error & ~(|fault_event) &
                          ~any_latched;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_q <= `AFS_SHUT_RESET;
        end else begin
            shutdown_q <= in_shutdown;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overcurrent_threshold_select <= `AFS_OC_SEL_RESET;
        end else begin
            if (wr_fault) begin
                overcurrent_threshold_select <=
                    reg_wdata[`AFS_OC_SEL_MSB:`AFS_OC_SEL_LSB];
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oc_trip_level <= `AFS_TRIP_RESET;
        end else begin
            oc_trip_level <= next_oc_trip;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_fault_flag <= `AFS_FLAG_RESET;
        end else begin
            clock_fault_flag <= clk_error;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_latched <= `AFS_LATCH_RESET;
        end else begin
            fault_latched <= next_fault_latched;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clip_mid <= `AFS_CLIP_MID_RESET;
        end else begin
            if (wr_mid) begin
                clip_mid <= reg_wdata;
            end
        end
    end

    // reserved low bits are kept so a read returns what was written
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clip_low      <= `AFS_CLIP_LOW_RESET;
            clip_low_rsvd <= `AFS_RSVD_RESET;
        end else begin
            if (wr_low) begin
                clip_low      <= reg_wdata[7:2];
                clip_low_rsvd <= reg_wdata[1:0];
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            amp_run <= `AFS_RUN_RESET;
        end else begin
            amp_run <= next_amp_run;
        end
    end

    // reserved range and unmapped addresses read zero, writes dropped
    always @* begin
        case (reg_addr)
            `AFS_ADDR_FAULT:    reg_rdata = fault_byte(
                overcurrent_threshold_select, clock_fault_flag,
                {overcurrent_fault_flag, dc_offset_fault_flag,
                 overtemp_fault_flag});
            `AFS_ADDR_CLIP_MID: reg_rdata = clip_mid;
            `AFS_ADDR_CLIP_LOW: reg_rdata = {clip_low, clip_low_rsvd};
            default:            reg_rdata = 8'h00;
        endcase
    end

    assign clip_threshold = {clip_threshold_upper, clip_mid,
                             clip_low};
    assign clip_threshold_middle_out = clip_mid;
    assign clip_threshold_lower_out  = clip_low;
endmodule // afs_regs

// *** verilog/afs_defines.vh ***
// Purpose: constants for the amplifier fault status and clip threshold regs
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   definitions only
`ifndef AFS_DEFINES_VH
`define AFS_DEFINES_VH

`define AFS_ADDR_FAULT      8'h08
`define AFS_ADDR_RSVD_LO    8'h09
`define AFS_ADDR_RSVD_HI    8'h0F
`define AFS_ADDR_CLIP_MID   8'h10
`define AFS_ADDR_CLIP_LOW   8'h11

`define AFS_BIT_OTE         0
`define AFS_BIT_DCE         1
`define AFS_BIT_OCE         2
`define AFS_BIT_CLK         3
`define AFS_OC_SEL_LSB      4
`define AFS_OC_SEL_MSB      5

`define AFS_FAULT_RESET     8'h00
`define AFS_OC_SEL_RESET    2'h0
`define AFS_CLIP_MID_RESET  8'h01
`define AFS_CLIP_LOW_RESET  6'h01
`define AFS_RSVD_RESET      2'h0
`define AFS_FLAG_RESET      1'h0
`define AFS_LATCH_RESET     3'h0
`define AFS_SHUT_RESET      1'h0
`define AFS_TRIP_RESET      8'h00
`define AFS_RUN_RESET       1'h0

`endif

// *** verilog/afs_oc_scale.v ***
// Purpose: scale the nominal overcurrent trip level by the threshold select
// Assumes: nominal level is an unsigned code from the power stage
// Notes:   pure combinational, result registered by the caller
`timescale 1ns/1ns
module afs_oc_scale (
    // select and level
    input  wire [1:0] overcurrent_threshold_select,
    input  wire [7:0] oc_nominal,
    // scaled level
    output reg  [7:0] oc_trip
);
    wire [9:0] three_q = {2'h0, oc_nominal} + {1'h0, oc_nominal, 1'h0};

    always @* begin
        case (overcurrent_threshold_select)
            2'h0:    oc_trip = oc_nominal;
            2'h1:    oc_trip = three_q[9:2];
            2'h2:    oc_trip = {1'h0, oc_nominal[7:1]};
            2'h3:    oc_trip = {2'h0, oc_nominal[7:2]};
            default: oc_trip = oc_nominal;
        endcase
    end
endmodule // afs_oc_scale

// *** test/afs_regs_monitor.sv ***
// Purpose: afs_regs port checks
// Assumes: one clock domain
// Notes: flag checks need 0x08 held
`timescale 1ns/1ns
module afs_regs_monitor (
    input wire clk, arst_n, reg_wr, amp_shutdown_n, shutdown_bit_n,
    input wire reg_rd, reg_ack,
    input wire clk_error, overcurrent_event, dc_offset_event,
    input wire overtemp_event, amp_run,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire [7:0] clip_threshold_middle_out,
    input wire [5:0] clip_threshold_lower_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire f8 = reg_addr == 8'h08;
    wire on = amp_shutdown_n & shutdown_bit_n;
    wire ev = overcurrent_event | dc_offset_event | overtemp_event;
    property p_rsv; f8 |-> reg_rdata[7:6] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_clk; f8 |-> reg_rdata[3] == $past(clk_error); endproperty
    a_clk: assert property (p_clk) else $error("clock flag");
    property p_halt; ev |=> !amp_run; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    // latched flags may only drop two edges after a shutdown release
    property p_hold; f8 && $past(f8) && on && $past(on) && $past(on, 2)
        |-> &(~$past(reg_rdata) | reg_rdata | 8'hF8); endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_shut; !on |=> !amp_run; endproperty
    a_shut: assert property (p_shut) else $error("ran in shutdown");
    property p_ot; overtemp_event && f8 |=> reg_rdata[0]; endproperty
    a_ot: assert property (p_ot) else $error("temp flag");
    property p_mid; reg_wr && reg_addr == 8'h10
        |=> clip_threshold_middle_out == $past(reg_wdata); endproperty
    a_mid: assert property (p_mid) else $error("middle write");
    property p_low; reg_wr && reg_addr == 8'h11 |=>
        {clip_threshold_lower_out, 2'h0} == ($past(reg_wdata) & 8'hFC);
    endproperty
    a_low: assert property (p_low) else $error("lower write");
    property p_ack; reg_ack == (reg_wr | reg_rd); endproperty
    a_ack: assert property (p_ack) else $error("ack mismatch");
    c_halt: cover property (ev ##1 !amp_run);
    c_back: cover property (!on ##1 on);
    c_low: cover property (reg_wr && reg_addr == 8'h11);
endmodule // afs_regs_monitor
bind afs_regs afs_regs_monitor afs_regs_monitor_inst (.clk, .arst_n,
    .reg_wr, .amp_shutdown_n, .shutdown_bit_n, .clk_error, .amp_run,
    .reg_rd, .reg_ack,
    .overcurrent_event, .dc_offset_event, .overtemp_event, .reg_addr,
    .reg_wdata, .reg_rdata, .clip_threshold_middle_out,
    .clip_threshold_lower_out);

// *** test/afs_host_model.sv ***
// Purpose: host on the register port
// Assumes: requests start after a rising edge
// Notes: writes keep out of the reserved range
`timescale 1ns/1ns
module afs_host_model (
    input wire clk, input wire [7:0] reg_rdata,
    output reg reg_wr = 0, reg_rd = 0, output reg [7:0] reg_addr = 0,
    output reg [7:0] reg_wdata = 0
);
    task wr(input [7:0] a, d);
        if (a < 8'h09 || a > 8'h0F) begin
            @(posedge clk) {reg_addr, reg_wr} <= {a, 1'h1};
            reg_wdata <= a == 8'h11 ? d & 8'hFC : d;
            @(posedge clk) reg_wr <= 1'h0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'h1};
        @(posedge clk) d = reg_rdata;
        reg_rd <= 1'h0;
    endtask
endmodule // afs_host_model

// *** test/tb.sv ***
// Purpose: self-checking bench for afs_regs
// Assumes: host model drives the register port
// Notes: fixed seed, corners first
`timescale 1ns/1ns
module tb;
    reg clk = 0, arst_n = 0, sd_n = 1, sb_n = 1, ce = 0;
    reg [2:0] ev = 0;
    reg [7:0] nom = 0, d, e, q;
    reg [5:0] up = 0;
    reg [31:0] rv;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, trip;
    wire [19:0] clip;
    wire reg_wr, reg_rd, run;
    integer seed = 74373, num_errors = 0, check_count = 0, cyc = 0, i;
    afs_regs afs_regs_inst (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_ack(), .amp_shutdown_n(sd_n),
        .shutdown_bit_n(sb_n), .clk_error(ce), .overcurrent_event(ev[2]),
        .dc_offset_event(ev[1]), .overtemp_event(ev[0]), .oc_nominal(nom),
        .clip_threshold_upper(up), .clip_threshold(clip),
        .clip_threshold_middle_out(), .clip_threshold_lower_out(),
        .oc_trip_level(trip), .amp_run(run));
    afs_host_model afs_host_model_inst (.clk, .reg_rdata, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata);
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            chk("timeout", 0, 1);
            summarize;
        end
    end
    task chk(input string n, input [19:0] x, g);
        check_count = check_count + 1;
        if (g !== x) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s exp %h got %h", n, x, g);
        end
    endtask
    task w(input [7:0] a, v);
        afs_host_model_inst.wr(a, v);
    endtask
    task r(input [7:0] a, x, input string n);
        afs_host_model_inst.rd(a, q);
        chk(n, x, q);
    endtask
    // 75 percent truncates, as the power stage expects
    function [7:0] scl(input [1:0] s, input [9:0] n);
        scl = s == 0 ? n : s == 1 ? n * 3 >> 2 : n >> (s - 1);
    endfunction
    task summarize;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        r(8'h08, 8'h00, "fault");
        r(8'h10, 8'h01, "middle");
        r(8'h11, 8'h04, "lower");
        r(8'h20, 8'h00, "unmapped");
        for (i = 0; i < 8; i = i + 1) begin
            rv = $random(seed);
            d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : rv[7:0];
            e = ~d;
            {nom, up} <= rv[31:18];
            w(8'h10, d);
            w(8'h11, e);
            r(8'h10, d, "middle");
            r(8'h11, e & 8'hFC, "lower");
            chk("clip", {up, d, e[7:2]}, clip);
        end
        for (i = 0; i < 4; i = i + 1) begin
            w(8'h08, {2'h0, i[1:0], 4'hF});
            r(8'h08, {2'h0, i[1:0], 4'h0}, "fault");
            chk("trip", scl(i[1:0], {2'h0, nom}), trip);
        end
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge clk) ev <= 3'h1 << i;
            @(posedge clk) ev <= 3'h0;
            r(8'h08, 8'h30 | 8'h1 << i, "fault");
            @(negedge clk) chk("run", 0, run);
            @(posedge clk) {sd_n, sb_n} <= 2'h1 << i[0];
            @(posedge clk) {sd_n, sb_n} <= 2'h3;
            repeat (3) @(posedge clk);
            r(8'h08, 8'h30, "fault");
            @(negedge clk) chk("run", 1, run);
        end
        @(posedge clk) ce <= 1;
        r(8'h08, 8'h38, "fault");
        @(negedge clk) chk("run", 0, run);
        @(posedge clk) ce <= 0;
        repeat (3) @(posedge clk);
        r(8'h08, 8'h30, "fault");
        @(negedge clk) chk("run", 1, run);
        summarize;
    end
endmodule // tb
